/* tmrh_params.svh */
// Constants of the test message response handler: identifiers, layout, registers.
// Assumes inclusion by bare name from the package; the modules use its macros.
`ifndef TMRH_PARAMS_SVH
`define TMRH_PARAMS_SVH

// Identifiers received from the tester
`define TMRH_ID_STATUS_REQ 8'h35
`define TMRH_ID_IND_REQ 8'h36
`define TMRH_ID_PWR_REQ 8'h37
`define TMRH_ID_SM_REQ 8'h39
`define TMRH_ID_RESET 8'hFF
// Tester identifiers understood but not implemented here
`define TMRH_ID_VOL_UP 8'h33
`define TMRH_ID_VOL_DN 8'h34
`define TMRH_ID_BELL_REQ 8'h38
`define TMRH_ID_KEYS 8'h3A
`define TMRH_ID_HOOK_ON 8'h40
`define TMRH_ID_HOOK_OFF 8'h41
`define TMRH_ID_BEARER 8'h46
`define TMRH_ID_SET_PWR 8'h50
// Identifiers sent to the tester
`define TMRH_ID_STATUS_RSP 8'h5B
`define TMRH_ID_IND_RSP 8'h5C
`define TMRH_ID_PWR_RSP 8'h5D
`define TMRH_ID_SM_RSP 8'h65
`define TMRH_ID_NOSM_RSP 8'h66
`define TMRH_ID_FAULT 8'hF0
`define TMRH_ID_NOTREC 8'hF1
`define TMRH_ID_NOTPERF 8'hF2

// Message lengths in octets, identifier included
`define TMRH_LEN_STATUS 8'h03
`define TMRH_LEN_ONE_PAYLOAD 8'h02
`define TMRH_LEN_BARE 8'h01
// Short message field layout (field octet positions, lengths and store depth)
`define TMRH_SM_OA_FIRST 8'h01
`define TMRH_SM_SC_FIRST 8'h0D
`define TMRH_SM_PID_POS 8'h19
`define TMRH_SM_UDL_POS 8'h22
`define TMRH_SM_HDR_LEN 8'h23
`define TMRH_SM_UD_MAX 8'h8C
`define TMRH_SM_SLOT_LEN 4'hC
`define TMRH_SM_DEPTH 176

// Register byte offsets
`define TMRH_REG_CTRL 8'h00
`define TMRH_REG_STATUS 8'h04
`define TMRH_REG_IND 8'h08
`define TMRH_REG_POWER 8'h0C
`define TMRH_REG_SM_LEN 8'h10
`define TMRH_REG_SM_ADDR 8'h14
`define TMRH_REG_SM_DATA 8'h18
`define TMRH_REG_IRQ_STAT 8'h1C
`define TMRH_REG_IRQ_EN 8'h20
`define TMRH_REG_IRQ_CLR 8'h24
`define TMRH_REG_STATE 8'h28
// Reset values
`define TMRH_RST_BYTE 8'h00
`define TMRH_RST_WORD 32'h0000_0000
`define TMRH_RST_EV 5'h00
// Bus answers
`define TMRH_RESP_OKAY 2'h0
`define TMRH_RESP_SLVERR 2'h2
// Event bits
`define TMRH_EV_REQ 0
`define TMRH_EV_SENT 1
`define TMRH_EV_RESET 2
`define TMRH_EV_UNREC 3
`define TMRH_EV_RESEND 4
`define TMRH_EV_W 5

`endif

/* tmrh_pkg.sv */
// Types of the test message response handler.
// Assumes tmrh_params.svh is on the include path.
package tmrh_pkg;
	`include "tmrh_params.svh"

	typedef enum logic [0:0] {
		TMRH_IDLE = 1'b0,
		TMRH_SEND = 1'b1
	} tmrh_state_t;

	typedef enum logic [2:0] {
		TMRH_K_STATUS = 3'b000,
		TMRH_K_IND = 3'b001,
		TMRH_K_POWER = 3'b010,
		TMRH_K_SM = 3'b011,
		TMRH_K_NOSM = 3'b100,
		TMRH_K_FAULT = 3'b101,
		TMRH_K_NOTREC = 3'b110,
		TMRH_K_NOTPERF = 3'b111
	} tmrh_kind_t;
endpackage

/* tmrh_sm_store.sv */
// Short message field storage in flip-flops, one write port and one read port.
// Assumes the writer keeps the address below DEPTH; others are dropped.
module tmrh_sm_store
	import tmrh_pkg::*;
#(
	parameter int DEPTH = `TMRH_SM_DEPTH
)
(
	// Clock
	input wire logic clk,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	// Stored user data length octet
	output logic [7:0] udl
);
	logic [7:0] mem_q [DEPTH];
	logic [7:0] mem_d [DEPTH];

	always_comb
	begin
		mem_d = mem_q;
		if (wr_en && (int'(wr_addr) < DEPTH))
		begin
			mem_d[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		mem_q <= mem_d;
	end

	// No reset on storage: the present flag in the handler says if it is valid
	assign rd_data = (int'(rd_addr) < DEPTH) ? mem_q[rd_addr] : `TMRH_RST_BYTE;
	assign udl = mem_q[`TMRH_SM_UDL_POS];
endmodule // tmrh_sm_store

/* tmrh_handler.sv */
// Test message response handler: answers tester requests with octet messages.
// Assumes octet streams with valid/ready, and an AXI4-Lite master for setup.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
module tmrh_handler
	import tmrh_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Octets from the tester
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	output logic rx_ready,
	// Octets to the tester
	output logic tx_valid,
	output logic [7:0] tx_data,
	output logic tx_last,
	input wire logic tx_ready,
	// Full reset pulse and interrupt
	output logic full_reset_command,
	output logic irq
);
	function automatic logic [7:0] msg_id(input tmrh_kind_t k);
		unique case (k)
			TMRH_K_STATUS: msg_id = `TMRH_ID_STATUS_RSP;
			TMRH_K_IND: msg_id = `TMRH_ID_IND_RSP;
			TMRH_K_POWER: msg_id = `TMRH_ID_PWR_RSP;
			TMRH_K_SM: msg_id = `TMRH_ID_SM_RSP;
			TMRH_K_NOSM: msg_id = `TMRH_ID_NOSM_RSP;
			TMRH_K_FAULT: msg_id = `TMRH_ID_FAULT;
			TMRH_K_NOTREC: msg_id = `TMRH_ID_NOTREC;
			TMRH_K_NOTPERF: msg_id = `TMRH_ID_NOTPERF;
		endcase
	endfunction

	function automatic logic [7:0] msg_len(input tmrh_kind_t k, input logic [7:0] u);
		logic [7:0] uc;
		uc = (u > `TMRH_SM_UD_MAX) ? `TMRH_SM_UD_MAX : u;
		unique case (k)
			TMRH_K_STATUS: msg_len = `TMRH_LEN_STATUS;
			TMRH_K_IND, TMRH_K_POWER: msg_len = `TMRH_LEN_ONE_PAYLOAD;
			TMRH_K_SM: msg_len = 8'(`TMRH_LEN_BARE + `TMRH_SM_HDR_LEN + uc);
			TMRH_K_NOSM, TMRH_K_FAULT, TMRH_K_NOTREC, TMRH_K_NOTPERF:
				msg_len = `TMRH_LEN_BARE;
		endcase
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		for (int i = 0; i < 4; i++)
		begin
			wmerge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// Configuration and message state
	logic fault_q, fault_d, sm_present_q, sm_present_d;
	logic [15:0] status_q, status_d;
	logic ind_q, ind_d;
	logic [7:0] power_q, power_d, sm_addr_q, sm_addr_d;
	logic [3:0] oa_len_q, oa_len_d, sc_len_q, sc_len_d;
	tmrh_state_t state_q, state_d;
	tmrh_kind_t kind_q, kind_d, last_kind_q, last_kind_d;
	logic have_last_q, have_last_d, first_q, first_d;
	logic [7:0] id_q, id_d, idx_q, idx_d;
	logic rx_ready_q, rx_ready_d, tx_valid_q, tx_valid_d, tx_last_q, tx_last_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic rst_cmd_q, rst_cmd_d;
	// Bus and interrupt state, untouched by the commanded reset
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [`TMRH_EV_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, ev, clr;
	logic irq_q, irq_d;
	// Short message store access
	logic mem_we;
	logic [7:0] mem_wdata, mem_rd, udl, pay, req;
	tmrh_kind_t k;
	logic [31:0] wr_word;

	tmrh_sm_store #(.DEPTH(`TMRH_SM_DEPTH)) u_store (
		.clk(clk),
		.wr_en(mem_we),
		.wr_addr(sm_addr_q),
		.wr_data(mem_wdata),
		.rd_addr(idx_q),
		.rd_data(mem_rd),
		.udl(udl)
	);

	// Payload octet that follows octet idx_q; field position equals idx_q
	always_comb
	begin
		pay = `TMRH_RST_BYTE;
		unique case (kind_q)
			TMRH_K_STATUS: pay = (idx_q == `TMRH_RST_BYTE) ?
				{4'h0, status_q[3:0]} : status_q[15:8];
			TMRH_K_IND: pay = {7'h00, ind_q};
			TMRH_K_POWER: pay = power_q;
			TMRH_K_SM:
			begin
				if (idx_q == `TMRH_RST_BYTE)
				begin
					pay = `TMRH_RST_BYTE;
				end
				else if (idx_q < `TMRH_SM_SC_FIRST)
				begin
					pay = (idx_q - `TMRH_SM_OA_FIRST < {4'h0, oa_len_q}) ? mem_rd : 8'h00;
				end
				else if (idx_q < `TMRH_SM_PID_POS)
				begin
					pay = (idx_q - `TMRH_SM_SC_FIRST < {4'h0, sc_len_q}) ? mem_rd : 8'h00;
				end
				else
				begin
					pay = mem_rd;
				end
			end
			TMRH_K_NOSM, TMRH_K_FAULT, TMRH_K_NOTREC, TMRH_K_NOTPERF: pay = `TMRH_RST_BYTE;
		endcase
	end

	always_comb
	begin
		fault_d = fault_q;
		sm_present_d = sm_present_q;
		status_d = status_q;
		ind_d = ind_q;
		power_d = power_q;
		sm_addr_d = sm_addr_q;
		oa_len_d = oa_len_q;
		sc_len_d = sc_len_q;
		state_d = state_q;
		kind_d = kind_q;
		last_kind_d = last_kind_q;
		have_last_d = have_last_q;
		first_d = first_q;
		id_d = id_q;
		idx_d = idx_q;
		tx_valid_d = tx_valid_q;
		tx_last_d = tx_last_q;
		tx_data_d = tx_data_q;
		rst_cmd_d = 1'b0;
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		irq_en_d = irq_en_q;
		ev = `TMRH_RST_EV;
		clr = `TMRH_RST_EV;
		mem_we = 1'b0;
		mem_wdata = wdata_q[7:0];
		req = first_q ? rx_data : id_q;
		k = TMRH_K_NOTPERF;
		wr_word = `TMRH_RST_WORD;
		// Write channel: address and data accepted in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_hold_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready)
		begin
			bvalid_d = 1'b0;
		end
		if (aw_hold_q && w_hold_q && !bvalid_q)
		begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `TMRH_RESP_OKAY;
			unique case (8'(awaddr_q))
				`TMRH_REG_CTRL:
				begin
					wr_word = wmerge({30'h0, sm_present_q, fault_q}, wdata_q, wstrb_q);
					fault_d = wr_word[0];
					sm_present_d = wr_word[1];
				end
				`TMRH_REG_STATUS:
				begin
					wr_word = wmerge({16'h0, status_q}, wdata_q, wstrb_q);
					status_d = {wr_word[15:8], 4'h0, wr_word[3:0]};
				end
				`TMRH_REG_IND: ind_d = wstrb_q[0] ? wdata_q[0] : ind_q;
				`TMRH_REG_POWER: power_d = wstrb_q[0] ? wdata_q[7:0] : power_q;
				`TMRH_REG_SM_LEN:
				begin
					wr_word = wmerge({16'h0, sc_len_q, 4'h0, 4'h0, oa_len_q}, wdata_q, wstrb_q);
					oa_len_d = (wr_word[3:0] > `TMRH_SM_SLOT_LEN) ? `TMRH_SM_SLOT_LEN : wr_word[3:0];
					sc_len_d = (wr_word[15:12] > `TMRH_SM_SLOT_LEN) ? `TMRH_SM_SLOT_LEN :
						wr_word[15:12];
				end
				`TMRH_REG_SM_ADDR: sm_addr_d = wstrb_q[0] ? wdata_q[7:0] : sm_addr_q;
				`TMRH_REG_SM_DATA:
				begin
					// Auto-increment so a message loads with repeated writes
					mem_we = wstrb_q[0];
					sm_addr_d = wstrb_q[0] ? 8'(sm_addr_q + 8'h01) : sm_addr_q;
				end
				`TMRH_REG_IRQ_EN: irq_en_d = wstrb_q[0] ? wdata_q[`TMRH_EV_W-1:0] : irq_en_q;
				`TMRH_REG_IRQ_CLR: clr = wstrb_q[0] ? wdata_q[`TMRH_EV_W-1:0] : `TMRH_RST_EV;
				`TMRH_REG_IRQ_STAT, `TMRH_REG_STATE: bresp_d = `TMRH_RESP_OKAY;
				default: bresp_d = `TMRH_RESP_SLVERR;
			endcase
		end
		// Read channel
		if (rvalid_q && s_axi_rready)
		begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = `TMRH_RESP_OKAY;
			rdata_d = `TMRH_RST_WORD;
			unique case (8'(s_axi_araddr))
				`TMRH_REG_CTRL: rdata_d = {30'h0, sm_present_q, fault_q};
				`TMRH_REG_STATUS: rdata_d = {16'h0, status_q};
				`TMRH_REG_IND: rdata_d = {31'h0, ind_q};
				`TMRH_REG_POWER: rdata_d = {24'h0, power_q};
				`TMRH_REG_SM_LEN: rdata_d = {16'h0, sc_len_q, 4'h0, 4'h0, oa_len_q};
				`TMRH_REG_SM_ADDR: rdata_d = {24'h0, sm_addr_q};
				`TMRH_REG_IRQ_STAT: rdata_d = {27'h0, irq_stat_q};
				`TMRH_REG_IRQ_EN: rdata_d = {27'h0, irq_en_q};
				`TMRH_REG_STATE: rdata_d = {27'h0, have_last_q, last_kind_q, state_q};
				`TMRH_REG_SM_DATA, `TMRH_REG_IRQ_CLR: rdata_d = `TMRH_RST_WORD;
				default: rresp_d = `TMRH_RESP_SLVERR;
			endcase
		end
		arready_d = !rvalid_d;
		// Registered so the ready ports come straight from flops
		awready_d = !aw_hold_d;
		wready_d = !w_hold_d;
		// Message engine
		unique case (state_q)
			TMRH_IDLE:
			begin
				if (rx_valid && rx_ready_q)
				begin
					first_d = rx_last;
					if (first_q)
					begin
						id_d = rx_data;
					end
					// Extra octets are swallowed; action waits for the last one
					if (rx_last)
					begin
						if (req == `TMRH_ID_RESET)
						begin
							rst_cmd_d = 1'b1;
							ev[`TMRH_EV_RESET] = 1'b1;
						end
						else
						begin
							ev[`TMRH_EV_REQ] = 1'b1;
							unique case (req)
								`TMRH_ID_STATUS_REQ: k = TMRH_K_STATUS;
								`TMRH_ID_IND_REQ: k = TMRH_K_IND;
								`TMRH_ID_PWR_REQ: k = TMRH_K_POWER;
								`TMRH_ID_SM_REQ: k = sm_present_q ? TMRH_K_SM : TMRH_K_NOSM;
								`TMRH_ID_NOTREC:
								begin
									ev[`TMRH_EV_RESEND] = have_last_q;
									k = have_last_q ? last_kind_q : TMRH_K_NOTPERF;
								end
								`TMRH_ID_VOL_UP, `TMRH_ID_VOL_DN, `TMRH_ID_BELL_REQ, `TMRH_ID_KEYS,
								`TMRH_ID_HOOK_ON, `TMRH_ID_HOOK_OFF, `TMRH_ID_BEARER,
								`TMRH_ID_SET_PWR: k = TMRH_K_NOTPERF;
								default:
								begin
									ev[`TMRH_EV_UNREC] = 1'b1;
									k = TMRH_K_NOTREC;
								end
							endcase
							// A fault is only ever reported as an answer
							if (fault_q)
							begin
								k = TMRH_K_FAULT;
							end
							state_d = TMRH_SEND;
							kind_d = k;
							last_kind_d = k;
							have_last_d = 1'b1;
							idx_d = `TMRH_RST_BYTE;
							tx_valid_d = 1'b1;
							tx_data_d = msg_id(k);
							tx_last_d = (msg_len(k, udl) == `TMRH_LEN_BARE);
						end
					end
				end
			end
			TMRH_SEND:
			begin
				if (tx_valid_q && tx_ready)
				begin
					if (tx_last_q)
					begin
						state_d = TMRH_IDLE;
						tx_valid_d = 1'b0;
						tx_last_d = 1'b0;
						ev[`TMRH_EV_SENT] = 1'b1;
					end
					else
					begin
						tx_data_d = pay;
						idx_d = 8'(idx_q + 8'h01);
						tx_last_d = (8'(idx_q + 8'h02) == msg_len(kind_q, udl));
					end
				end
			end
		endcase
		rx_ready_d = (state_d == TMRH_IDLE) && !rst_cmd_d;
		// Set wins over a clear in the same cycle
		irq_stat_d = (irq_stat_q & ~clr) | ev;
		irq_d = |(irq_stat_d & irq_en_d);
	end

	always_ff @(posedge clk)
	begin
		if (srst || rst_cmd_q)
		begin
			fault_q <= 1'b0;
			sm_present_q <= 1'b0;
			status_q <= 16'h0000;
			ind_q <= 1'b0;
			power_q <= `TMRH_RST_BYTE;
			sm_addr_q <= `TMRH_RST_BYTE;
			oa_len_q <= 4'h0;
			sc_len_q <= 4'h0;
			state_q <= TMRH_IDLE;
			kind_q <= TMRH_K_NOTPERF;
			last_kind_q <= TMRH_K_NOTPERF;
			have_last_q <= 1'b0;
			first_q <= 1'b1;
			id_q <= `TMRH_RST_BYTE;
			idx_q <= `TMRH_RST_BYTE;
			rx_ready_q <= 1'b0;
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_data_q <= `TMRH_RST_BYTE;
		end
		else
		begin
			fault_q <= fault_d;
			sm_present_q <= sm_present_d;
			status_q <= status_d;
			ind_q <= ind_d;
			power_q <= power_d;
			sm_addr_q <= sm_addr_d;
			oa_len_q <= oa_len_d;
			sc_len_q <= sc_len_d;
			state_q <= state_d;
			kind_q <= kind_d;
			last_kind_q <= last_kind_d;
			have_last_q <= have_last_d;
			first_q <= first_d;
			id_q <= id_d;
			idx_q <= idx_d;
			rx_ready_q <= rx_ready_d;
			tx_valid_q <= tx_valid_d;
			tx_last_q <= tx_last_d;
			tx_data_q <= tx_data_d;
		end
		// Bus and interrupt state survive the commanded reset so no transfer is torn
		if (srst)
		begin
			rst_cmd_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= `TMRH_RST_WORD;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= `TMRH_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= `TMRH_RST_WORD;
			rresp_q <= `TMRH_RESP_OKAY;
			arready_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			irq_stat_q <= `TMRH_RST_EV;
			irq_en_q <= `TMRH_RST_EV;
			irq_q <= 1'b0;
		end
		else
		begin
			rst_cmd_q <= rst_cmd_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			arready_q <= arready_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			irq_q <= irq_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign rx_ready = rx_ready_q;
	assign tx_valid = tx_valid_q;
	assign tx_data = tx_data_q;
	assign tx_last = tx_last_q;
	assign full_reset_command = rst_cmd_q;
	assign irq = irq_q;
endmodule // tmrh_handler

/* tmrh_tester.sv */
// Tester model: sends one-octet request messages and takes reply octets.
// Assumes the bench calls send only between replies and sets slow for stalls.
module tmrh_tester
(
	// Clock
	input wire logic clk,
	// Requests to the handler
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_last,
	input wire logic rx_ready,
	// Replies from the handler
	input wire logic tx_valid,
	output logic tx_ready,
	// Stall mode
	input wire logic slow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt_q = 2'h0;

	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_last = 1'b0;
		tx_ready = 1'b1;
	end

	// Slow mode takes one octet in four, so holding is exercised
	always @(posedge clk)
	begin
		cnt_q <= cnt_q + 2'h1;
		tx_ready <= !slow || cnt_q == 2'h0;
	end

	task automatic send(input logic [7:0] id, output logic ok);
		int n;
		rx_valid <= 1'b1;
		rx_data <= id;
		rx_last <= 1'b1;
		for (n = 0; n < 3000; n++)
		begin
			@(posedge clk);
			if (rx_ready)
				break;
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		// Released data line shows the inverse, not a stale copy
		rx_data <= ~id;
		ok = (n < 3000);
	endtask
endmodule // tmrh_tester

/* tmrh_handler_checker.sv */
// Concurrent checks on the response handler ports.
// Assumes one clock, synchronous active-high reset; bound below.
module tmrh_handler_checker
	import tmrh_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bus answers
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Message link
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_last,
	input wire logic rx_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic tx_ready,
	// Reset pulse and interrupt
	input wire logic full_reset_command,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic in_msg_q, in_msg_d;

	// Only the first octet of a message is its identifier
	always_comb
	begin
		in_msg_d = in_msg_q;
		if (rx_valid && rx_ready)
			in_msg_d = !rx_last;
	end
	always_ff @(posedge clk)
		in_msg_q <= srst ? 1'b0 : in_msg_d;

	sequence s_req(logic [7:0] id);
		rx_valid && rx_ready && rx_last && !in_msg_q && rx_data == id;
	endsequence
	sequence s_done;
		tx_valid && tx_ready && tx_last;
	endsequence
	sequence s_reopen;
		!tx_valid && !tx_last && rx_ready;
	endsequence

	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !tx_valid && !irq && !s_axi_bvalid
		&& !s_axi_rvalid && !full_reset_command) else $error("output active after reset");
	a_status_reply: assert property (s_req(8'h35) |=> tx_valid && !rx_ready
		&& tx_data inside {8'h5B, 8'hF0}) else $error("status reply missing");
	a_unknown_id: assert property (s_req(8'h01) |=> tx_valid && tx_data inside {8'hF1, 8'hF0})
		else $error("unknown id not refused");
	a_reset_pulse: assert property (s_req(8'hFF) |=> full_reset_command && !tx_valid
		##1 !full_reset_command) else $error("reset pulse wrong");
	a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
		&& $stable(tx_last)) else $error("reply octet changed while held");
	a_rx_blocked: assert property (tx_valid |-> !rx_ready) else $error("request taken mid reply");
	a_reply_close: assert property (s_done |=> s_reopen) else $error("link not reopened");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer repeated");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
endmodule // tmrh_handler_checker

bind tmrh_handler tmrh_handler_checker #(.ADDR_W(ADDR_W)) i_tmrh_handler_checker (.*);

/* tb.sv */
// Self-checking bench: AXI4-Lite setup, tester requests, reply octets queued.
// Assumes the tester model and the bound checker compile before it.
module tb
	import tmrh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data, pw, v;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ok, slow;
	logic [31:0] s_axi_wdata, s_axi_rdata, st, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, full_reset_command, irq;
	logic [8:0] exp_q[$];
	logic [7:0] nid[8] = '{8'h33, 8'h34, 8'h38, 8'h3A, 8'h40, 8'h41, 8'h46, 8'h50};
	int mismatches = 0;
	int compares = 0;
	int resets = 0;
	int i, p;
	integer seed = 32'h8251_5db5;

	always #5 clk = ~clk;

	tmrh_handler i_tmrh_handler (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid,
		.tx_data, .tx_last, .tx_ready, .full_reset_command, .irq);
	tmrh_tester i_tmrh_tester (.clk, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid,
		.tx_ready, .slow);

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want)
		begin
			mismatches++;
			$display("FAIL %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic hang();
		mismatches++;
		$display("FAIL %0t wait ran out", $time);
		end_sim();
	endtask

	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (n == 40)
			hang();
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, r);
		// Gap edge so the next call never reassigns a strobe in this step
		@(posedge clk);
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 40; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (n == 40)
			hang();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic ex(input logic [7:0] d, input logic l);
		exp_q.push_back({l, d});
	endtask

	// Sends one request, then waits for every noted octet to come back
	task automatic req(input logic [7:0] id);
		int n;
		i_tmrh_tester.send(id, ok);
		if (!ok)
			hang();
		for (n = 0; n < 2000 && exp_q.size() > 0; n++)
			@(posedge clk);
		if (n == 2000)
			hang();
		repeat (3) @(posedge clk);
	endtask

	function automatic logic [7:0] smv(input int q);
		return (q == 34) ? 8'h02 : 8'(q + 64);
	endfunction

	always @(posedge clk)
	begin
		if (full_reset_command === 1'b1)
			resets++;
		if (tx_valid === 1'b1 && tx_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(32'h0000_0001, 32'h0000_0000);
			else
				chk({tx_last, tx_data}, exp_q.pop_front());
		end
	end

	initial
	begin
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_rready = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		slow = 1'b0;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		st = $random(seed);
		pw = $random(seed);
		axw(8'h04, st, 2'h0);
		axw(8'h08, 32'h0000_0001, 2'h0);
		axw(8'h0C, {24'h0, pw}, 2'h0);
		axw(8'h20, 32'h0000_0001, 2'h0);
		axw(8'h3C, st, 2'h2);
		axr(8'h04, rd, rr);
		chk(rd, st & 32'h0000_FF0F);
		axr(8'h3C, rd, rr);
		chk(rr, 2'h2);
		chk(rd, 32'h0000_0000);
		ex(8'h5B, 1'b0);
		ex({4'h0, st[3:0]}, 1'b0);
		ex(st[15:8], 1'b1);
		req(8'h35);
		chk(irq, 1'b1);
		axr(8'h1C, rd, rr);
		chk(rd[0], 1'b1);
		axw(8'h24, 32'h0000_001F, 2'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		slow <= 1'b1;
		ex(8'h5C, 1'b0);
		ex(8'h01, 1'b1);
		req(8'h36);
		ex(8'h5D, 1'b0);
		ex(pw, 1'b1);
		req(8'h37);
		slow <= 1'b0;
		ex(8'h66, 1'b1);
		req(8'h39);
		ex(8'hF1, 1'b1);
		req(8'h01);
		for (i = 0; i < 8; i++)
		begin
			ex(8'hF2, 1'b1);
			req(nid[i]);
		end
		for (i = 0; i < 2; i++)
		begin
			ex(8'h5D, 1'b0);
			ex(pw, 1'b1);
			req(i == 0 ? 8'h37 : 8'hF1);
		end
		axw(8'h00, 32'h0000_0002, 2'h0);
		axw(8'h10, 32'h0000_3002, 2'h0);
		axw(8'h14, 32'h0000_0001, 2'h0);
		for (p = 1; p <= 36; p++)
			axw(8'h18, {24'h0, smv(p)}, 2'h0);
		ex(8'h65, 1'b0);
		for (p = 0; p <= 36; p++)
		begin
			v = (p == 0 || (p > 2 && p < 13) || (p > 15 && p < 25)) ? 8'h00 : smv(p);
			ex(v, p == 36);
		end
		req(8'h39);
		axw(8'h00, 32'h0000_0003, 2'h0);
		ex(8'hF0, 1'b1);
		req(8'h35);
		req(8'hFF);
		chk(resets, 1);
		axr(8'h04, rd, rr);
		chk(rd, 32'h0000_0000);
		ex(8'h66, 1'b1);
		req(8'h39);
		end_sim();
	end
endmodule // tb
